// ==== logic/pfc_config_master.sv ====
`timescale 1ns/10ps
/*
  Parallel flash configuration master: streams 16-bit words from a shared NOR flash.
  Assumes config_request_n and chip select come from pins; flash data passes two
  flip-flops, so each word is taken two system cycles after its clock period ends.
*/
module pfc_config_master
  import pfc_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic srst, // synchronous reset, high
  input wire logic configRequestN, // config request pin, low resets
  input wire logic chipSelectN, // chip select pin, low grants flash to us
  input wire logic flashWait, // flash wait, ignored during configuration
  input wire logic [pfc_pkg::DATA_W-1:0] flashDataIn, // flash data bus
  input wire logic setBootAddressInstruction, // boot-address instruction strobe
  input wire logic [pfc_pkg::ADDR_W-1:0] bootAddrValue, // value for that instruction
  input wire logic [pfc_pkg::ADDR_W-1:0] wordCount, // words to fetch, 0 = default
  output pfc_pkg::pfc_flash_out_t flashOut, // flash control and address outputs
  output logic flashOutEnable, // high while we drive the flash outputs
  output pfc_pkg::pfc_word_t wordOut, // fetched word, one-cycle valid
  output logic configDone // high after all words fetched
);
  logic [1:0] reqSync;
  logic [1:0] csSync;
  logic reqN;
  logic csN;
  logic [ADDR_W-1:0] bootAddr;
  pfc_state_t state_reg;
  pfc_state_t state_next;
  logic [3:0] divCnt_reg;
  logic clkPhase_reg;
  logic riseTick;
  logic fallTick;
  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] left_reg;
  logic [DATA_W-1:0] dataSync1;
  logic [DATA_W-1:0] dataSync2;
  logic owned;
  logic [1:0] wordPipe_reg;

  // address and stream phases both drive the flash and run the clock
  function automatic logic in_fetch(input pfc_state_t s);
    return (s == PFC_ADDR) || (s == PFC_STREAM);
  endfunction

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reqSync <= 2'h0;
      csSync <= 2'h3;
    end else begin
      reqSync <= {reqSync[0], configRequestN};
      csSync <= {csSync[0], chipSelectN};
    end
  end
  assign reqN = reqSync[1];
  assign csN = csSync[1];
  // ownership: request released and chip select low
  assign owned = reqN && !csN;

  pfc_boot_addr_reg bootReg (
    .clk_sys(clk_sys),
    .srst(srst),
    .loadStrobe(setBootAddressInstruction),
    .loadValue(bootAddrValue),
    .bootAddr(bootAddr)
  );

  // configuration clock from our own divider; parked low outside the address and
  // stream phases so the flash sees no stray edges after the last word
  always_ff @(posedge clk_sys) begin
    if (srst || !in_fetch(state_reg)) begin
      divCnt_reg <= 4'h0;
      clkPhase_reg <= 1'b0;
    end else if (divCnt_reg == CFG_HALF_CYCLES - 4'h1) begin
      divCnt_reg <= 4'h0;
      clkPhase_reg <= ~clkPhase_reg;
    end else begin
      divCnt_reg <= divCnt_reg + 4'h1;
    end
  end
  assign riseTick = in_fetch(state_reg) && !clkPhase_reg
    && (divCnt_reg == CFG_HALF_CYCLES - 4'h1);
  assign fallTick = in_fetch(state_reg) && clkPhase_reg
    && (divCnt_reg == CFG_HALF_CYCLES - 4'h1);

  // flash wait is deliberately not an input to any decision here
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      PFC_IDLE: if (owned) state_next = PFC_ADDR;
      PFC_ADDR: if (fallTick) state_next = PFC_STREAM;
      PFC_STREAM: if (fallTick && left_reg == 24'h000001) state_next = PFC_DONE;
      PFC_DONE: state_next = PFC_DONE;
    endcase
    if (!reqN || csN) state_next = PFC_IDLE;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= PFC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst || state_reg == PFC_IDLE) begin
      addr_reg <= bootAddr;
      left_reg <= (wordCount == 24'h0) ? WORD_COUNT_RST : wordCount;
    end else if (state_reg == PFC_STREAM && fallTick) begin
      addr_reg <= addr_reg + 24'h1;
      left_reg <= left_reg - 24'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dataSync1 <= 16'h0;
      dataSync2 <= 16'h0;
    end else begin
      dataSync1 <= flashDataIn;
      dataSync2 <= dataSync1;
    end
  end

  // the flash answer needs two system cycles through the input flip-flops, so a word
  // is taken two cycles after the falling edge that closes its clock period
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wordPipe_reg <= 2'h0;
    end else begin
      wordPipe_reg <= {wordPipe_reg[0], (state_reg == PFC_STREAM) && fallTick};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wordOut <= '0;
    end else begin
      wordOut.valid <= wordPipe_reg[1];
      wordOut.word <= dataSync2;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      configDone <= 1'b0;
    end else begin
      // held back until the last word has left the pipeline
      configDone <= (state_reg == PFC_DONE) && (state_next == PFC_DONE)
        && (wordPipe_reg == 2'h0);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flashOut <= '{flashAddressBus: 24'h0, addressValidN: 1'b1,
        flashOutputEnableN: 1'b1, writeStrobeN: 1'b1, flashChipEnableN: 1'b1,
        configClockOut: 1'b0};
      flashOutEnable <= 1'b0;
    end else begin
      flashOutEnable <= (state_next != PFC_IDLE);
      flashOut.flashAddressBus <= addr_reg;
      flashOut.addressValidN <= !(state_next == PFC_ADDR);
      flashOut.flashOutputEnableN <= !(state_next == PFC_STREAM);
      flashOut.writeStrobeN <= 1'b1;
      flashOut.flashChipEnableN <= !in_fetch(state_next);
      flashOut.configClockOut <= (state_next == PFC_IDLE) ? 1'b0 :
        (riseTick ? 1'b1 : (fallTick ? 1'b0 : clkPhase_reg));
    end
  end
endmodule

// ==== logic/pfc_pkg.sv ====
/*
  Package for the parallel flash configuration master: timing counts, boot address,
  pin groups carried as packed structs.
  Assumes a 50 MHz system clock that stands in for the internal configuration oscillator.
*/
// Contract
// - while config_request_n is low all flash outputs are released
// - chip select input level decides who owns the shared flash
// - flash wait indication is ignored during configuration
// - the whole transfer is clocked by our own config_clock_out
// - config_clock_out is at least 20 MHz, period at most 50 ns
// - one full 16-bit word moves per configuration clock cycle
// - default start is word address 0x010000, byte address 0x020000
// - boot address replaceable by the set_boot_address_instruction
// - drive active-low address valid, output enable and write strobes
package pfc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned CFG_CLK_MAX_PERIOD_NS = 50;
  // half period in system cycles, rounded down so the clock never runs slower than allowed
  localparam int unsigned CFG_HALF_CYCLES_INT = (CFG_CLK_MAX_PERIOD_NS / 2) / CLK_PERIOD_NS;
  localparam logic [3:0] CFG_HALF_CYCLES =
    (CFG_HALF_CYCLES_INT < 1) ? 4'h1 : 4'(CFG_HALF_CYCLES_INT);
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned DATA_W = 16;
  localparam logic [ADDR_W-1:0] BOOT_ADDR_WORD_RST = 24'h010000;
  localparam logic [ADDR_W-1:0] BOOT_ADDR_BYTE_RST = 24'h020000;
  localparam logic [ADDR_W-1:0] WORD_COUNT_RST = 24'h000100;

  typedef enum {PFC_IDLE, PFC_ADDR, PFC_STREAM, PFC_DONE} pfc_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] flashAddressBus;
    logic addressValidN;
    logic flashOutputEnableN;
    logic writeStrobeN;
    logic flashChipEnableN;
    logic configClockOut;
  } pfc_flash_out_t;

  typedef struct packed {
    logic [DATA_W-1:0] word;
    logic valid;
  } pfc_word_t;
endpackage

// ==== logic/pfc_boot_addr_reg.sv ====
`timescale 1ns/10ps
/*
  Boot address holder for the configuration master, loaded by the test-access
  boot-address instruction. Assumes the load strobe is on the system clock.
*/
module pfc_boot_addr_reg
  import pfc_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic srst, // synchronous reset, high
  input wire logic loadStrobe, // one-cycle load from the test port
  input wire logic [pfc_pkg::ADDR_W-1:0] loadValue, // new word address
  output logic [pfc_pkg::ADDR_W-1:0] bootAddr // current boot word address
);
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bootAddr <= BOOT_ADDR_WORD_RST;
    end else if (loadStrobe) begin
      bootAddr <= loadValue;
    end
  end
endmodule

// ==== bench/pfc_flash_model.sv ====
`timescale 1ns/10ps
/*
  Flash model in asynchronous read mode with a fixed data pattern.
  Assumes the master drives the strobes only while flashOutEnable is high.
*/
module pfc_flash_model
  import pfc_pkg::*;
(
  input logic clk_sys, // system clock
  input pfc_pkg::pfc_flash_out_t flashOut, // master strobes
  input logic flashOutEnable, // master drives strobes
  output logic [pfc_pkg::DATA_W-1:0] flashDataIn // read data
);
  logic [DATA_W-1:0] last = 16'h0;
  wire rd = flashOutEnable && !flashOut.flashChipEnableN && !flashOut.flashOutputEnableN;
  // a floating bus toggles every cycle so a late sample cannot pass by luck
  always @(posedge clk_sys) begin
    last <= flashDataIn;
  end
  // content stands for an image that a host wrote through the four test pins
  logic [DATA_W-1:0] image;
  assign image = flashOut.flashAddressBus[15:0]
    ^ {8'h5a, flashOut.flashAddressBus[23:16]};
  assign flashDataIn = rd ? image : ~last;
endmodule

// ==== bench/pfc_config_master_properties.sv ====
`timescale 1ns/10ps
/*
  Port checker for the configuration master.
  Assumes binding to pfc_config_master on one clock.
*/
module pfc_config_master_properties
  import pfc_pkg::*;
(
  input logic clk_sys, // clock
  input logic srst, // reset
  input logic configRequestN, // request pin
  input logic chipSelectN, // select pin
  input pfc_pkg::pfc_flash_out_t flashOut, // flash pins
  input logic flashOutEnable, // drive enable
  input pfc_pkg::pfc_word_t wordOut, // word
  input logic configDone // done
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  rel_req_a: assert property (!configRequestN [*6] |-> !flashOutEnable)
    else $error("bus held in reset");
  rel_cs_a: assert property (chipSelectN [*6] |-> !flashOutEnable)
    else $error("bus held without select");
  clk_rate_a: assert property (
    $rose(flashOut.configClockOut) && !configDone |=> !flashOut.configClockOut || configDone)
    else $error("clock too slow");
  word_rate_a: assert property (wordOut.valid |=> !wordOut.valid)
    else $error("word pulse too long");
  no_write_a: assert property (flashOutEnable |-> flashOut.writeStrobeN)
    else $error("write strobe low");
  start_a: assert property (
    $rose(flashOutEnable) |-> !flashOut.addressValidN && !flashOut.flashChipEnableN)
    else $error("bad start");
  addr_step_a: assert property (
    flashOutEnable && $past(flashOutEnable) && $changed(flashOut.flashAddressBus)
    |-> flashOut.flashAddressBus == $past(flashOut.flashAddressBus) + 24'h1)
    else $error("address step wrong");
  rd_strobe_a: assert property (
    flashOutEnable && !flashOut.flashOutputEnableN |-> flashOut.addressValidN)
    else $error("read during address");
  done_stop_a: assert property (
    configDone && $past(configDone) && flashOutEnable |-> $stable(flashOut.configClockOut))
    else $error("clock runs after done");
endmodule
bind pfc_config_master pfc_config_master_properties i_props (.clk_sys, .srst,
  .configRequestN, .chipSelectN, .flashOut, .flashOutEnable, .wordOut, .configDone);

// ==== bench/test_parallel_flash_config_master.sv ====
`timescale 1ns/10ps
/*
  Self-checking bench: boot fetch, hand-over to another master, new boot address.
  Assumes the flash model's pattern; expected words come from a queue.
*/
module test_parallel_flash_config_master;
  import pfc_pkg::*;
  logic clk_sys = 0, srst = 1, configRequestN = 0, chipSelectN = 0, flashWait = 0;
  logic setBootAddressInstruction = 0, configDone, flashOutEnable;
  logic [23:0] bootAddrValue = 24'h0, wordCount = 24'h2;
  logic [15:0] flashDataIn;
  pfc_flash_out_t flashOut;
  pfc_word_t wordOut;
  int error_cnt = 0, n_tests = 0, seed = 32'h754a957f;
  logic [15:0] expq[$];
  always #10 clk_sys = ~clk_sys;
  pfc_config_master i_dut (.clk_sys, .srst, .configRequestN, .chipSelectN, .flashWait,
    .flashDataIn, .setBootAddressInstruction, .bootAddrValue, .wordCount, .flashOut,
    .flashOutEnable, .wordOut, .configDone);
  pfc_flash_model i_flash (.clk_sys, .flashOut, .flashOutEnable, .flashDataIn);
  task automatic chk(string nm, logic [23:0] e, logic [23:0] s);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic print_verdict;
    if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  always @(posedge clk_sys) begin
    flashWait <= #1 1'($random(seed));
    if (wordOut.valid === 1'b1) begin
      if (expq.size() == 0) chk("extra word", 24'h0, 24'h1);
      else chk("word", {8'h0, expq.pop_front()}, {8'h0, wordOut.word});
    end
  end
  task automatic run(logic [23:0] b);
    logic [23:0] a;
    int n;
    n = (wordCount == 24'h0) ? int'(WORD_COUNT_RST) : int'(wordCount);
    for (int i = 0; i < n; i++) begin
      a = b + 24'(i);
      expq.push_back(a[15:0] ^ {8'h5a, a[23:16]});
    end
    configRequestN = 1;
    for (int t = 0; t < 1000 && configDone !== 1'b1; t++) cyc(1);
    cyc(4);
    chk("done", 24'h1, {23'h0, configDone});
    chk("left", 0, 24'(expq.size()));
  endtask
  task automatic handover(logic [23:0] nb);
    configRequestN = 0;
    cyc(25);
    chk("release", 24'h0, {23'h0, flashOutEnable});
    chipSelectN = 1;
    setBootAddressInstruction = 1;
    bootAddrValue = nb;
    cyc(1);
    setBootAddressInstruction = 0;
    configRequestN = 1;
    cyc(10);
    chk("cs owner", 24'h0, {23'h0, flashOutEnable});
    chipSelectN = 0;
    configRequestN = 0;
    cyc(25);
    run(nb);
  endtask
  initial begin
    wordCount = 24'(2 + {$random(seed)} % 8);
    cyc(8);
    srst = 0;
    run(BOOT_ADDR_WORD_RST);
    for (int k = 0; k < 2; k++) handover(24'($random(seed)));
    // a zero count must fall back to the default word count
    wordCount = 24'h0;
    handover(24'($random(seed)));
    print_verdict;
  end
  initial begin
    cyc(5000);
    error_cnt++;
    print_verdict;
  end
endmodule
